/* File: pkg/ssp_pkg.sv */
// ==========================================================
// Serial programming port constants
// ==========================================================
package ssp_pkg;

	// ==========================================================
	// Clock and timing
	// ==========================================================
	localparam int SYS_CLK_MHZ      = 100;   // System clock rate
	localparam int FL_TICK_NS       = 1000;  // Fast-lock timeout unit, in ns
	// Cycles per timeout unit, rounded down (shortest time)
	localparam int FL_TICK_CYCLES   = (FL_TICK_NS * SYS_CLK_MHZ) / 1000;

	// ==========================================================
	// Shift register and addressing
	// ==========================================================
	localparam int SR_WIDTH         = 22;    // Programming word length
	localparam int ADDR_LSB         = 0;     // Address: last two bits shifted
	localparam int ADDR_WIDTH       = 2;
	localparam logic [1:0] ADDR_REF  = 2'h0; // Reference divider word
	localparam logic [1:0] ADDR_MAIN = 2'h1; // Main divider word
	localparam logic [1:0] ADDR_FUNC = 2'h2; // Function word
	localparam logic [21:0] WORD_RST = 22'h00_0000; // Word reset value

	// ==========================================================
	// Function word fields
	// ==========================================================
	localparam int FN_PRESC_BIT     = 2;     // 1: upper modulus pair
	localparam int FN_MUX_LSB       = 3;     // Multifunction pin select
	localparam int FN_MUX_WIDTH     = 2;
	localparam int FN_FL_EN_BIT     = 5;     // Fast-lock enable
	localparam int FN_TO_LSB        = 6;     // Timeout counter field
	localparam int FN_TO_WIDTH      = 4;
	localparam int FN_FRC_LSB       = 8;     // Upper two bits of timeout field
	localparam int FN_FRC_WIDTH     = 2;

	// ==========================================================
	// Prescaler moduli (lower value of each pair)
	// ==========================================================
	localparam logic [5:0] MOD_32   = 6'h20;
	localparam logic [5:0] MOD_16   = 6'h10;
	localparam logic [5:0] MOD_8    = 6'h08;

	// Multifunction pin sources
	typedef enum logic [1:0] {
		MUX_DIG_LOCK = 2'b00,
		MUX_ANA_LOCK = 2'b01,
		MUX_REF_DIV  = 2'b10,
		MUX_MAIN_DIV = 2'b11
	} ssp_mux_t;

	// Fast-lock pin override codes
	typedef enum logic [1:0] {
		FRC_NORMAL = 2'b00,
		FRC_HIZ    = 2'b01,
		FRC_LOW    = 2'b10,
		FRC_HIGH   = 2'b11
	} ssp_force_t;

endpackage : ssp_pkg

/* File: src/ssp_sync.sv */
`timescale 1ns/1ps
// ==========================================================
// Two-flop synchroniser for asynchronous pins
// ==========================================================
module ssp_sync #(
	parameter int WIDTH = 1         // Number of independent bits
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_r;       // First stage, read only by second
	logic [WIDTH-1:0] sync_r;       // Second stage, safe to use

	// ==========================================================
	// Two stages; nothing but the second stage reads the first
	// ==========================================================
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			meta_r <= '0;
			sync_r <= '0;
		end
		else
		begin
			meta_r <= async_in;
			sync_r <= meta_r;
		end
	end

	assign sync_out = sync_r;

endmodule : ssp_sync

/* File: src/ssp_top.sv */
`timescale 1ns/1ps
module ssp_top
	import ssp_pkg::*;
#(
	parameter int  TICK_CYCLES = ssp_pkg::FL_TICK_CYCLES, // Timeout unit length
	parameter bit  LOW_FREQ    = 1'b0                     // 1: lowest-frequency variant
) (
	input  wire logic                        sys_clk,
	input  wire logic                        rst,
	input  wire logic                        ser_clk,
	input  wire logic                        ser_data,
	input  wire logic                        load_strobe,
	input  wire logic                        chip_enable,
	input  wire logic                        dig_lock_in,
	input  wire logic                        ana_lock_in,
	input  wire logic                        ref_div_in,
	input  wire logic                        main_div_in,
	output logic [ssp_pkg::SR_WIDTH-1:0]     ref_word,
	output logic [ssp_pkg::SR_WIDTH-1:0]     main_word,
	output logic [ssp_pkg::SR_WIDTH-1:0]     func_word,
	output logic                             power_down,
	output logic                             fast_lock_active,
	output logic                             fast_lock_out,
	output logic                             fast_lock_oe,
	output logic                             multifunction_status_out,
	output logic                             multifunction_status_oe,
	output logic                             presc_upper_sel,
	output logic [5:0]                       presc_modulus
);

	import ssp_pkg::*;

	// ==========================================================
	// Pin synchronisation
	// ==========================================================
	logic [3:0]             pins_s;          // Synchronised pin levels
	logic                   sclk_s;          // Serial clock, synchronised
	logic                   sdat_s;          // Serial data, synchronised
	logic                   strb_s;          // Load strobe, synchronised
	logic                   ce_s;            // Chip enable, synchronised
	logic                   sclk_d_r;        // Serial clock, one cycle later
	logic                   strb_d_r;        // Load strobe, one cycle later
	logic                   sclk_rise;       // Serial clock rising edge
	logic                   strb_rise;       // Load strobe rising edge

	// All four pins share one synchroniser so their skew stays equal
	ssp_sync #(
		.WIDTH (4)
	) u_sync (
		.clk      (sys_clk),
		.rst      (rst),
		.async_in ({ser_clk, ser_data, load_strobe, chip_enable}),
		.sync_out (pins_s)
	);

	assign sclk_s = pins_s[3];
	assign sdat_s = pins_s[2];
	assign strb_s = pins_s[1];
	assign ce_s   = pins_s[0];

	// Edge detect history
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			sclk_d_r <= 1'b0;
			strb_d_r <= 1'b0;
		end
		else
		begin
			sclk_d_r <= sclk_s;
			strb_d_r <= strb_s;
		end
	end

	assign sclk_rise = sclk_s & ~sclk_d_r;
	assign strb_rise = strb_s & ~strb_d_r;

	// ==========================================================
	// Shift register
	// ==========================================================
	logic [SR_WIDTH-1:0]    shift_r;         // Incoming programming word
	logic [ADDR_WIDTH-1:0]  addr;            // Address field of the word

	// Data is synchronised with the clock, so both arrive together;
	// the host's setup time keeps the sampled data bit settled.
	// capture on rise
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			shift_r <= WORD_RST;
		else if (sclk_rise)
			shift_r <= {shift_r[SR_WIDTH-2:0], sdat_s};
	end

	assign addr = shift_r[ADDR_LSB +: ADDR_WIDTH];

	// ==========================================================
	// Control registers
	// ==========================================================
	logic [SR_WIDTH-1:0]    ref_word_r;      // Reference divider word
	logic [SR_WIDTH-1:0]    main_word_r;     // Main divider word
	logic [SR_WIDTH-1:0]    func_word_r;     // Function word

	// Only a complete word is meaningful; the host keeps the strobe
	// low while shifting, so the copy happens after the last bit.
	// load on strobe rise
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			ref_word_r  <= WORD_RST;
			main_word_r <= WORD_RST;
			func_word_r <= WORD_RST;
		end
		else if (strb_rise)
		begin
			unique case (addr)
				ADDR_REF:  ref_word_r  <= shift_r;
				ADDR_MAIN: main_word_r <= shift_r;
				ADDR_FUNC: func_word_r <= shift_r;
				default:   ; // Fourth address has no register
			endcase
		end
	end

	assign ref_word  = ref_word_r;
	assign main_word = main_word_r;
	assign func_word = func_word_r;

	// ==========================================================
	// Power-down
	// ==========================================================
	logic                   pd_r;            // Logical power-down state

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			pd_r <= 1'b1;
		else
			pd_r <= ~ce_s;
	end

	assign power_down = pd_r;

	// ==========================================================
	// Fast-lock timeout
	// ==========================================================
	localparam int TW = $clog2(TICK_CYCLES + 1);
	logic [TW-1:0]          tick_cnt_r;      // Timeout unit divider
	logic                   tick;            // One cycle per timeout unit
	logic [FN_TO_WIDTH-1:0] timer_r;         // Remaining fast-lock units
	logic                   fl_en;           // Fast-lock enabled
	logic                   fl_act;          // Fast-lock mode active
	ssp_force_t             force_code;      // Fast-lock pin override

	assign fl_en      = func_word_r[FN_FL_EN_BIT];
	assign force_code = ssp_force_t'(func_word_r[FN_FRC_LSB +: FN_FRC_WIDTH]);
	assign tick       = (tick_cnt_r == TW'(TICK_CYCLES - 1));

	// Free-running unit divider
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			tick_cnt_r <= '0;
		else if (tick)
			tick_cnt_r <= '0;
		else
			tick_cnt_r <= tick_cnt_r + TW'(1);
	end

	// A new main divider word starts fast-lock for the programmed units
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			timer_r <= '0;
		else if (strb_rise && addr == ADDR_MAIN && fl_en)
			timer_r <= func_word_r[FN_TO_LSB +: FN_TO_WIDTH];
		else if (!fl_en || pd_r)
			timer_r <= '0;
		else if (tick && timer_r != '0)
			timer_r <= timer_r - FN_TO_WIDTH'(1);
	end

	assign fl_act = fl_en && (timer_r != '0);

	// ==========================================================
	// Fast-lock pin
	// ==========================================================
	logic                   fl_out_r;        // Fast-lock pin level
	logic                   fl_oe_r;         // Fast-lock pin drive enable
	logic                   fl_act_r;        // Fast-lock mode, registered

	// Override wins over the mode; normal code follows the mode
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			fl_out_r <= 1'b0;
			fl_oe_r  <= 1'b0;
			fl_act_r <= 1'b0;
		end
		else
		begin
			fl_act_r <= fl_act;
			unique case (force_code)
				FRC_HIZ:
				begin
					fl_out_r <= 1'b0;
					fl_oe_r  <= 1'b0;
				end
				FRC_LOW:
				begin
					fl_out_r <= 1'b0;
					fl_oe_r  <= 1'b1;
				end
				FRC_HIGH:
				begin
					fl_out_r <= 1'b1;
					fl_oe_r  <= 1'b1;
				end
				FRC_NORMAL:
				begin
					fl_out_r <= 1'b0;
					fl_oe_r  <= fl_act;
				end
			endcase
		end
	end

	assign fast_lock_out    = fl_out_r;
	assign fast_lock_oe     = fl_oe_r;
	assign fast_lock_active = fl_act_r;

	// ==========================================================
	// Multifunction pin
	// ==========================================================
	ssp_mux_t               mux_sel;         // Selected source
	logic                   mf_out_r;        // Pin level
	logic                   mf_oe_r;         // Pin drive enable

	assign mux_sel = ssp_mux_t'(func_word_r[FN_MUX_LSB +: FN_MUX_WIDTH]);

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			mf_out_r <= 1'b0;
			mf_oe_r  <= 1'b1;
		end
		else
		begin
			unique case (mux_sel)
				MUX_DIG_LOCK:
				begin
					mf_out_r <= dig_lock_in;
					mf_oe_r  <= 1'b1;
				end
				// Open drain: pull low when unlocked, release when locked
				MUX_ANA_LOCK:
				begin
					mf_out_r <= 1'b0;
					mf_oe_r  <= ~ana_lock_in;
				end
				MUX_REF_DIV:
				begin
					mf_out_r <= ref_div_in;
					mf_oe_r  <= 1'b1;
				end
				MUX_MAIN_DIV:
				begin
					mf_out_r <= main_div_in;
					mf_oe_r  <= 1'b1;
				end
			endcase
		end
	end

	assign multifunction_status_out = mf_out_r;
	assign multifunction_status_oe  = mf_oe_r;

	// ==========================================================
	// Prescaler modulus selection
	// ==========================================================
	logic                   psel_r;          // Upper pair selected
	logic [5:0]             pmod_r;          // Lower modulus of the pair

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			psel_r <= 1'b0;
			pmod_r <= LOW_FREQ ? MOD_8 : MOD_16;
		end
		else
		begin
			psel_r <= func_word_r[FN_PRESC_BIT];
			if (func_word_r[FN_PRESC_BIT])
				pmod_r <= LOW_FREQ ? MOD_16 : MOD_32;
			else
				pmod_r <= LOW_FREQ ? MOD_8 : MOD_16;
		end
	end

	assign presc_upper_sel = psel_r;
	assign presc_modulus   = pmod_r;

	// ==========================================================
	// Assertions
	// ==========================================================
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_shift_capture: assert property (sclk_rise |=> shift_r[0] == $past(sdat_s)
		&& shift_r[SR_WIDTH-1:1] == $past(shift_r[SR_WIDTH-2:0]))
		else $error("shift register missed a bit");

	a_shift_idle: assert property (!sclk_rise && !strb_rise |=> $stable(shift_r))
		else $error("shift register moved without clock");

	a_load_route: assert property (strb_rise && addr == ADDR_FUNC
		|=> func_word_r == $past(shift_r) && $stable(ref_word_r) && $stable(main_word_r))
		else $error("function word load misrouted");

	a_load_ref: assert property (strb_rise && addr == ADDR_REF |=> ref_word_r == $past(shift_r))
		else $error("reference word not loaded");

	a_load_noop: assert property (!strb_rise |=> $stable(main_word_r) && $stable(ref_word_r))
		else $error("control word changed without strobe");

	a_power_down: assert property (!ce_s |=> power_down)
		else $error("chip enable low did not power down");

	a_fl_low: assert property (fl_act && force_code == FRC_NORMAL
		|=> fast_lock_oe && !fast_lock_out)
		else $error("fast-lock pin not low in fast-lock mode");

	a_fl_release: assert property (!fl_act && force_code == FRC_NORMAL |=> !fast_lock_oe)
		else $error("fast-lock pin driven outside fast-lock mode");

	a_fl_force: assert property (force_code == FRC_HIGH ##1 force_code == FRC_HIGH
		|-> fast_lock_oe && fast_lock_out)
		else $error("fast-lock force high not applied");

	a_mf_ref: assert property (mux_sel == MUX_REF_DIV |=> mf_oe_r && mf_out_r == $past(ref_div_in))
		else $error("multifunction pin not showing reference divider");

	a_presc_pair: assert property (func_word_r[FN_PRESC_BIT] [*2]
		|-> presc_modulus == (LOW_FREQ ? MOD_16 : MOD_32))
		else $error("prescaler modulus does not follow selection");

	c_load_main:   cover property (strb_rise && addr == ADDR_MAIN);
	c_fast_lock:   cover property (fl_act [*3]);
	c_force_high:  cover property (force_code == FRC_HIGH ##1 fast_lock_out);
	c_analog_lock: cover property (mux_sel == MUX_ANA_LOCK && !mf_oe_r);

endmodule : ssp_top

/* File: test/ssp_host_model.sv */
`timescale 1ns/1ps
// ==========================================================
// Host model: three-wire programming master
// ==========================================================
module ssp_host_model (
	output logic ser_clk,     // Serial clock, idle low
	output logic ser_data,    // Serial data
	output logic load_strobe  // Load strobe, idle low
);

	// Idle levels; serial clock stands still between frames
	initial
	begin
		ser_clk     = 1'b0;
		ser_data    = 1'b0;
		load_strobe = 1'b0;
	end

	// ==========================================================
	// Word transfer, 80 ns serial period
	// ==========================================================
	task automatic send_word(input logic [21:0] w);
		// most significant bit goes out first
		for (int i = 21; i >= 0; i--)
		begin
			ser_data = w[i];
			#40 ser_clk = ~ser_clk;
			#40 ser_clk = ~ser_clk;
		end
		// Hold time over: data line no longer trustworthy
		ser_data = ~ser_data;
		// strobe stays low until the last edge is long past
		#60 load_strobe = ~load_strobe;
		#60 load_strobe = ~load_strobe;
	endtask : send_word

endmodule : ssp_host_model

/* File: test/tb_top.sv */
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the serial programming port
// ==========================================================
module tb_top;
	import ssp_pkg::*;

	localparam int TICKS = 8; // Short timeout unit keeps runs brief

	logic        sys_clk;     // System clock
	logic        rst;         // Async reset
	logic        ser_clk;     // From host model
	logic        ser_data;    // From host model
	logic        load_strobe; // From host model
	logic        chip_enable; // Power control pin
	logic [3:0]  src;         // Lock and divider sources
	logic [21:0] ref_word;    // Loaded words
	logic [21:0] main_word;
	logic [21:0] func_word;
	logic        power_down;  // Status outputs
	logic        fl_act;
	logic        fl_out;
	logic        fl_oe;
	logic        mf_out;
	logic        mf_oe;
	logic        presc_upper_sel;
	logic [5:0]  presc_modulus;
	logic [5:0]  presc_mod_low; // Lowest-frequency variant modulus
	int          num_errors;  // Mismatch count
	int          num_checks;  // Comparison count

	ssp_host_model host (
		.ser_clk     (ser_clk),
		.ser_data    (ser_data),
		.load_strobe (load_strobe)
	);

	ssp_top #(
		.TICK_CYCLES (TICKS),
		.LOW_FREQ    (1'b0)
	) dut (
		.sys_clk                  (sys_clk),
		.rst                      (rst),
		.ser_clk                  (ser_clk),
		.ser_data                 (ser_data),
		.load_strobe              (load_strobe),
		.chip_enable              (chip_enable),
		.dig_lock_in              (src[0]),
		.ana_lock_in              (src[1]),
		.ref_div_in               (src[2]),
		.main_div_in              (src[3]),
		.ref_word                 (ref_word),
		.main_word                (main_word),
		.func_word                (func_word),
		.power_down               (power_down),
		.fast_lock_active         (fl_act),
		.fast_lock_out            (fl_out),
		.fast_lock_oe             (fl_oe),
		.multifunction_status_out (mf_out),
		.multifunction_status_oe  (mf_oe),
		.presc_upper_sel          (presc_upper_sel),
		.presc_modulus            (presc_modulus)
	);

	// Lowest-frequency variant on the same pins; only its prescaler is watched
	ssp_top #(
		.TICK_CYCLES (TICKS),
		.LOW_FREQ    (1'b1)
	) dut_low (
		.sys_clk                  (sys_clk),
		.rst                      (rst),
		.ser_clk                  (ser_clk),
		.ser_data                 (ser_data),
		.load_strobe              (load_strobe),
		.chip_enable              (chip_enable),
		.dig_lock_in              (src[0]),
		.ana_lock_in              (src[1]),
		.ref_div_in               (src[2]),
		.main_div_in              (src[3]),
		.ref_word                 (),
		.main_word                (),
		.func_word                (),
		.power_down               (),
		.fast_lock_active         (),
		.fast_lock_out            (),
		.fast_lock_oe             (),
		.multifunction_status_out (),
		.multifunction_status_oe  (),
		.presc_upper_sel          (),
		.presc_modulus            (presc_mod_low)
	);

	// ==========================================================
	// Clock and helpers
	// ==========================================================
	initial sys_clk = 1'b0;
	always #5 sys_clk = ~sys_clk;

	// Advance n edges, then step just past the edge
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : step

	// Word-sized comparison
	task automatic chk_val(input logic [21:0] got, input logic [21:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_val

	// Single-bit comparison
	task automatic chk_bit(input logic got, input logic exp);
		num_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_bit

	// Build a function word from its fields
	function automatic logic [21:0] fw(logic [1:0] mux, logic pre, logic fl, logic [3:0] to);
		logic [21:0] w;
		w = 22'h00_0000;
		w[ADDR_LSB +: ADDR_WIDTH] = ADDR_FUNC;
		w[FN_PRESC_BIT] = pre;
		w[FN_MUX_LSB +: FN_MUX_WIDTH] = mux;
		w[FN_FL_EN_BIT] = fl;
		w[FN_TO_LSB +: FN_TO_WIDTH] = to;
		return w;
	endfunction : fw

	// Single exit point of the run
	task automatic report_and_stop();
		$display("checks=%0d errors=%0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : report_and_stop

	// Watchdog well beyond the roughly 27 us of tests
	initial
	begin
		#300000;
		num_errors++;
		report_and_stop();
	end

	// ==========================================================
	// Test sequence
	// ==========================================================
	initial
	begin
		num_errors  = 0;
		num_checks  = 0;
		rst         = 1'b1;
		chip_enable = 1'b1;
		src         = 4'h0;
		step(6);
		rst = 1'b0;
		step(4);
		// Nothing loaded yet, device awake
		chk_val(ref_word, WORD_RST);
		chk_bit(power_down, 1'b0);
		chk_val({16'h0000, presc_modulus}, {16'h0000, MOD_16});
		chk_val({16'h0000, presc_mod_low}, {16'h0000, MOD_8});
		// each address reaches its own register
		host.send_word(22'h2A_5C30);
		host.send_word(22'h15_A3C5);
		host.send_word(fw(MUX_REF_DIV, 1'b1, 1'b0, 4'h0));
		step(3);
		chk_val(ref_word, 22'h2A_5C30);
		chk_val(main_word, 22'h15_A3C5);
		chk_val(func_word, fw(MUX_REF_DIV, 1'b1, 1'b0, 4'h0));
		chk_bit(presc_upper_sel, 1'b1);
		chk_val({16'h0000, presc_modulus}, {16'h0000, MOD_32});
		chk_val({16'h0000, presc_mod_low}, {16'h0000, MOD_16});
		host.send_word(22'h3F_FFFF);
		step(3);
		chk_val(ref_word, 22'h2A_5C30);
		chk_val(main_word, 22'h15_A3C5);
		chk_val(func_word, fw(MUX_REF_DIV, 1'b1, 1'b0, 4'h0));
		// every source, others held opposite so a wrong pick shows
		for (int m = 0; m < 4; m++)
		begin
			host.send_word(fw(m[1:0], 1'b0, 1'b0, 4'h0));
			for (int v = 0; v < 2; v++)
			begin
				src = (v == 1) ? (4'h1 << m) : ~(4'h1 << m);
				step(4);
				chk_bit(mf_out, (m == 1) ? 1'b0 : v[0]);
				chk_bit(mf_oe, (m == 1) ? ~v[0] : 1'b1);
			end
			chk_val({16'h0000, presc_modulus}, {16'h0000, MOD_16});
		end
		// override codes on the fast-lock pin
		for (int f = 1; f < 4; f++)
		begin
			host.send_word(fw(MUX_DIG_LOCK, 1'b0, 1'b0, 4'(f << 2)));
			step(3);
			chk_bit(fl_oe, f != 1);
			chk_bit(fl_out, f == 3);
		end
		// timed fast-lock started by a main word load
		host.send_word(fw(MUX_DIG_LOCK, 1'b0, 1'b1, 4'h3));
		host.send_word(22'h15_A3C5);
		step(3);
		chk_bit(fl_act, 1'b1);
		chk_bit(fl_oe, 1'b1);
		chk_bit(fl_out, 1'b0);
		step(3 * TICKS + 6);
		chk_bit(fl_act, 1'b0);
		chk_bit(fl_oe, 1'b0);
		// power down mid fast-lock stops it
		host.send_word(22'h15_A3C5);
		chip_enable = ~chip_enable;
		// Two sync stages, power-down, timer clear, then the registered flag
		step(5);
		chk_bit(power_down, 1'b1);
		chk_bit(fl_act, 1'b0);
		chip_enable = ~chip_enable;
		step(4);
		chk_bit(power_down, 1'b0);
		// Mid-run reset returns the words and power state to idle
		rst = 1'b1;
		step(2);
		chk_val(main_word, WORD_RST);
		chk_val(func_word, WORD_RST);
		chk_bit(power_down, 1'b1);
		rst = 1'b0;
		step(4);
		chk_bit(power_down, 1'b0);
		chk_val({16'h0000, presc_mod_low}, {16'h0000, MOD_8});
		report_and_stop();
	end

endmodule : tb_top
